//--- reader_ctl_pkg.sv
// Package with register map, reset values, timing figures and state types.
package reader_ctl_pkg;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDR = 8'h08;
	localparam logic [7:0] OFS_SYMB = 8'h0C;
	localparam int CTRL_SERVICE_BIT = 0;
	localparam int CTRL_FAULT_BIT = 1;
	localparam int CTRL_COMM_ERR_BIT = 2;
	localparam int CTRL_BUS_ERR_BIT = 3;
	localparam logic [3:0] CTRL_RESET = 4'h0;
	localparam logic [15:0] SYMB_ENABLE_RESET = 16'hFFFF;
	localparam logic [7:0] I25_DIGITS_RESET = 8'h0A;
	localparam int SYMB_I25_LSB = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam longint CLK_HZ = 100_000_000;
	localparam longint FLASH_HALF_MS = 250;
	localparam longint BLINK_MS = 100;
	localparam longint SCREEN_MS = 1000;
	localparam longint BAUD_RATE = 9600;
	localparam int UART_DATA_BITS = 8;
	localparam int UART_STOP_BITS = 1;
	localparam int FLASH_HALF_CYC = int'(FLASH_HALF_MS * CLK_HZ / 1000);
	localparam int BLINK_CYC = int'(BLINK_MS * CLK_HZ / 1000);
	localparam int SCREEN_CYC = int'(SCREEN_MS * CLK_HZ / 1000);
	localparam int BAUD_CYC = int'(CLK_HZ / BAUD_RATE);
	localparam int RANGE_STEP = 16;
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 32;
	typedef enum logic [2:0] {
		PWR_INIT, PWR_STEADY, PWR_OFF_GOOD, PWR_OFF_BAD, PWR_RED_BAD
	} pwr_state_t;
	typedef enum logic [1:0] {
		SCR_STARTUP, SCR_DESIGNATION, SCR_RESULT
	} screen_t;
endpackage

//--- result_fifo.sv
// Synchronous FIFO for decoded result bytes.
`timescale 1ns/100ps
module result_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	// Fill level
	output logic [$clog2(DEPTH):0] count_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem[rd_q];
	assign count_o = cnt_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

//--- reader_startup_status_trigger.sv
// Start-up, status indicator, address and read-trigger control of the reader.
`timescale 1ns/100ps
module reader_startup_status_trigger
	import reader_ctl_pkg::*;
#(
	parameter int FLASH_CYC = FLASH_HALF_CYC,
	parameter int BLINK_LEN = BLINK_CYC,
	parameter int SCREEN_LEN = SCREEN_CYC,
	parameter int BAUD_LEN = BAUD_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins: switches and switching input
	input wire logic address_range_switch_i,
	input wire logic [3:0] address_low_selector_i,
	input wire logic read_trigger_i,
	// Decoder side
	input wire logic result_done_i,
	input wire logic result_good_i,
	input wire logic [7:0] result_data_i,
	input wire logic result_valid_i,
	output logic result_ready_o,
	output logic read_gate_o,
	output logic [15:0] symbology_enable_o,
	output logic [7:0] i25_digits_o,
	// Network side
	input wire logic master_ack_i,
	output logic net_register_o,
	output logic [7:0] net_data_o,
	output logic net_valid_o,
	input wire logic net_ready_i,
	output logic [4:0] net_address_o,
	// Host serial link
	output logic host_txd_o,
	// Indicators and display
	output logic power_status_led_green_o,
	output logic power_status_led_red_o,
	output logic bus_status_led_green_o,
	output logic bus_status_led_red_o,
	output logic [1:0] display_screen_o,
	output logic display_update_o
);
	function automatic logic [4:0] form_address(input logic range,
			input logic [3:0] low);
		form_address = 5'(int'(range) * RANGE_STEP + int'(low));
	endfunction

	logic [5:0] pin_s1_q;
	logic [5:0] pin_s2_q;
	logic [1:0] boot_q;
	logic [4:0] addr_q;
	logic [3:0] ctrl_q;
	logic [15:0] symb_q;
	logic [7:0] i25_q;
	logic [31:0] flash_cnt_q;
	logic flash_q;
	logic [31:0] scr_cnt_q;
	screen_t screen_q;
	pwr_state_t pwr_q;
	logic [31:0] blink_cnt_q;
	logic registered_q;
	logic upd_q;
	logic aw_q;
	logic w_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic net_mode;
	logic ready;
	logic trig_s;
	logic fifo_valid;
	logic fifo_pop;
	logic [7:0] fifo_data;
	logic [5:0] fifo_cnt;
	logic net_valid_q;
	logic [7:0] net_data_q;
	logic [9:0] tx_sh_q;
	logic [3:0] tx_bits_q;
	logic [31:0] baud_q;
	logic wr_fire;

	// Pin inputs pass two flip-flops before use.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= {read_trigger_i, address_range_switch_i,
				address_low_selector_i};
			pin_s2_q <= pin_s1_q;
		end
	end
	assign trig_s = pin_s2_q[5];

	// The switches are read once, after the synchroniser has filled.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			boot_q <= '0;
			addr_q <= '0;
		end else if (boot_q != 2'h3) begin
			boot_q <= boot_q + 2'h1;
			if (boot_q == 2'h2) begin
				addr_q <= form_address(pin_s2_q[4], pin_s2_q[3:0]);
			end
		end
	end
	assign net_mode = (addr_q != 5'h00);
	assign net_address_o = addr_q;
	assign net_register_o = net_mode && (boot_q == 2'h3) && !registered_q
		&& !ctrl_q[CTRL_BUS_ERR_BIT];

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			registered_q <= 1'b0;
		end else if (net_register_o && master_ack_i) begin
			registered_q <= 1'b1;
		end
	end

	// Start-up screen sequence; the reader is usable only on the result screen.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			screen_q <= SCR_STARTUP;
			scr_cnt_q <= '0;
		end else if (screen_q != SCR_RESULT) begin
			if (scr_cnt_q == 32'(SCREEN_LEN - 1)) begin
				scr_cnt_q <= '0;
				screen_q <= (screen_q == SCR_STARTUP) ? SCR_DESIGNATION
					: SCR_RESULT;
			end else begin
				scr_cnt_q <= scr_cnt_q + 32'h1;
			end
		end
	end
	assign display_screen_o = screen_q;
	assign ready = (screen_q == SCR_RESULT) && !ctrl_q[CTRL_FAULT_BIT]
		&& (!net_mode || registered_q);
	assign read_gate_o = ready && trig_s;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flash_cnt_q <= '0;
			flash_q <= 1'b0;
		end else if (flash_cnt_q == 32'(FLASH_CYC - 1)) begin
			flash_cnt_q <= '0;
			flash_q <= !flash_q;
		end else begin
			flash_cnt_q <= flash_cnt_q + 32'h1;
		end
	end

	// Power indicator sequence after each reading attempt.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pwr_q <= PWR_INIT;
			blink_cnt_q <= '0;
			upd_q <= 1'b0;
		end else begin
			upd_q <= 1'b0;
			case (pwr_q)
			PWR_INIT: begin
				if (screen_q == SCR_RESULT) begin
					pwr_q <= PWR_STEADY;
				end
			end
			PWR_STEADY: begin
				blink_cnt_q <= '0;
				if (result_done_i) begin
					pwr_q <= result_good_i ? PWR_OFF_GOOD : PWR_OFF_BAD;
					upd_q <= result_good_i;
				end
			end
			PWR_OFF_GOOD, PWR_OFF_BAD, PWR_RED_BAD: begin
				if (blink_cnt_q == 32'(BLINK_LEN - 1)) begin
					blink_cnt_q <= '0;
					pwr_q <= (pwr_q == PWR_OFF_BAD) ? PWR_RED_BAD
						: PWR_STEADY;
				end else begin
					blink_cnt_q <= blink_cnt_q + 32'h1;
				end
			end
			default: begin
				pwr_q <= PWR_INIT;
			end
			endcase
		end
	end
	assign display_update_o = upd_q;

	// Fault outranks service mode, which outranks the normal sequence.
	always_comb begin
		power_status_led_green_o = 1'b0;
		power_status_led_red_o = 1'b0;
		if (ctrl_q[CTRL_FAULT_BIT]) begin
			power_status_led_red_o = 1'b1;
		end else if (ctrl_q[CTRL_SERVICE_BIT]) begin
			power_status_led_green_o = 1'b1;
			power_status_led_red_o = 1'b1;
		end else begin
			case (pwr_q)
			PWR_INIT: power_status_led_green_o = flash_q;
			PWR_STEADY: power_status_led_green_o = 1'b1;
			PWR_RED_BAD: power_status_led_red_o = 1'b1;
			default: power_status_led_green_o = 1'b0;
			endcase
		end
	end

	always_comb begin
		bus_status_led_green_o = 1'b0;
		bus_status_led_red_o = 1'b0;
		if (net_mode) begin
			if (ctrl_q[CTRL_BUS_ERR_BIT]) begin
				bus_status_led_red_o = 1'b1;
			end else if (ctrl_q[CTRL_COMM_ERR_BIT]) begin
				bus_status_led_red_o = flash_q;
			end else if (registered_q) begin
				bus_status_led_green_o = 1'b1;
			end else begin
				bus_status_led_green_o = flash_q;
			end
		end
	end

	result_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.in_valid_i(result_valid_i),
		.in_ready_o(result_ready_o),
		.in_data_i(result_data_i),
		.out_valid_o(fifo_valid),
		.out_ready_i(fifo_pop),
		.out_data_o(fifo_data),
		.count_o(fifo_cnt)
	);

	// The drain stalls while the serial shifter or the network stage is busy.
	assign fifo_pop = fifo_valid && (net_mode ? (!net_valid_q || net_ready_i)
		: (tx_bits_q == 4'h0));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			net_valid_q <= 1'b0;
			net_data_q <= '0;
		end else if (net_mode && fifo_pop) begin
			net_valid_q <= 1'b1;
			net_data_q <= fifo_data;
		end else if (net_ready_i) begin
			net_valid_q <= 1'b0;
		end
	end
	assign net_valid_o = net_valid_q;
	assign net_data_o = net_data_q;

	// Serial frame: start bit, eight data bits LSB first, no parity, stop.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_sh_q <= 10'h3FF;
			tx_bits_q <= '0;
			baud_q <= '0;
		end else if (!net_mode && fifo_pop) begin
			tx_sh_q <= {1'b1, fifo_data, 1'b0};
			tx_bits_q <= 4'(1 + UART_DATA_BITS + UART_STOP_BITS);
			baud_q <= '0;
		end else if (tx_bits_q != 4'h0) begin
			if (baud_q == 32'(BAUD_LEN - 1)) begin
				baud_q <= '0;
				tx_sh_q <= {1'b1, tx_sh_q[9:1]};
				tx_bits_q <= tx_bits_q - 4'h1;
			end else begin
				baud_q <= baud_q + 32'h1;
			end
		end
	end
	assign host_txd_o = tx_sh_q[0];

	// AXI4-Lite write path: address and data taken in either order.
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready = !w_q && !bvalid_q;
	assign wr_fire = aw_q && w_q && !bvalid_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q <= (awaddr_q == OFS_CTRL || awaddr_q == OFS_SYMB)
					? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_q <= CTRL_RESET;
			symb_q <= SYMB_ENABLE_RESET;
			i25_q <= I25_DIGITS_RESET;
		end else if (wr_fire) begin
			if (awaddr_q == OFS_CTRL && wstrb_q[0]) begin
				ctrl_q <= wdata_q[3:0];
			end
			if (awaddr_q == OFS_SYMB) begin
				if (wstrb_q[0]) symb_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) symb_q[15:8] <= wdata_q[15:8];
				if (wstrb_q[2]) i25_q <= wdata_q[23:16];
			end
		end
	end
	assign symbology_enable_o = symb_q;
	assign i25_digits_o = i25_q;

	// AXI4-Lite read path: one cycle from address to data.
	assign s_axi_arready = !rvalid_q;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rresp_q <= RESP_OKAY;
			case (s_axi_araddr)
			OFS_CTRL: rdata_q <= {28'h0, ctrl_q};
			OFS_STATUS: rdata_q <= {17'h0, fifo_cnt, read_gate_o, pwr_q,
				screen_q, registered_q, net_mode, ready};
			OFS_ADDR: rdata_q <= {27'h0, addr_q};
			OFS_SYMB: rdata_q <= {8'h0, i25_q, symb_q};
			default: begin
				rdata_q <= '0;
				rresp_q <= RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
endmodule

//--- reader_ctl_assertions.sv
// Checker watching the ports of the reader control block.
`timescale 1ns/100ps
module reader_ctl_checker (
	// Clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pins and streams
	input wire logic read_trigger_i,
	input wire logic read_gate_o,
	input wire logic net_valid_o,
	input wire logic net_ready_i,
	input wire logic [7:0] net_data_o,
	input wire logic net_register_o,
	input wire logic [4:0] net_address_o,
	input wire logic host_txd_o,
	input wire logic [1:0] display_screen_o,
	input wire logic display_update_o,
	input wire logic bus_status_led_green_o,
	input wire logic bus_status_led_red_o
);
	logic [2:0] boot_q;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// Counts edges after reset so the address is judged only once latched.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			boot_q <= 3'h0;
		else if (boot_q != 3'h6)
			boot_q <= boot_q + 3'h1;
	end
	a_gate_trigger: assert property (read_gate_o |->
		$past(read_trigger_i, 2)) else $error("Gate without trigger.");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("Bad write answer.");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("Bad read answer.");
	a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("Read taken while answer pending.");
	a_screen_order: assert property (display_screen_o !=
		$past(display_screen_o) |-> display_screen_o ==
		$past(display_screen_o) + 2'h1) else $error("Screen order broken.");
	a_update_ready: assert property (display_update_o |->
		display_screen_o == 2'h2) else $error("Update before ready.");
	a_net_hold: assert property (net_valid_o && !net_ready_i |=>
		net_valid_o && $stable(net_data_o)) else $error("Result dropped.");
	a_addr_frozen: assert property (boot_q == 3'h6 |->
		$stable(net_address_o)) else $error("Address changed.");
	a_register_net: assert property (net_register_o |->
		net_address_o != 5'h00) else $error("Registering at address 0.");
	a_net_silent: assert property (boot_q == 3'h6 &&
		net_address_o != 5'h00 |-> host_txd_o) else $error("Serial in net.");
	a_bus_dark: assert property (boot_q == 3'h6 &&
		net_address_o == 5'h00 |-> !bus_status_led_green_o &&
		!bus_status_led_red_o) else $error("Bus indicator lit alone.");
	a_start_bit: assert property ($fell(host_txd_o) |->
		!host_txd_o [*3]) else $error("Start bit too short.");
	c_update: cover property (display_update_o);
	c_serial: cover property ($fell(host_txd_o));
	c_net: cover property (net_valid_o && net_ready_i);
endmodule
bind reader_startup_status_trigger reader_ctl_checker u_chk (.*);

//--- net_master_model.sv
// Network master model: registers the slave and takes its result bytes.
`timescale 1ns/100ps
module net_master_model #(
	parameter int ACK_DLY = 20
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Network side of the reader
	input wire logic net_register_i,
	input wire logic net_valid_i,
	input wire logic [7:0] net_data_i,
	output logic master_ack_o,
	output logic net_ready_o,
	// Bytes taken, for the bench
	output logic [7:0] got_o,
	output logic [7:0] got_n_o
);
	logic [7:0] wait_q;
	// Recognition is late so the bus indicator can be seen flashing.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wait_q <= 8'h00;
			master_ack_o <= 1'b0;
		end else if (net_register_i && !master_ack_o) begin
			wait_q <= wait_q + 8'h01;
			master_ack_o <= wait_q == 8'(ACK_DLY);
		end
	end
	// Random stalls make a result wait several cycles to be taken.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			net_ready_o <= 1'b0;
			got_o <= 8'h00;
			got_n_o <= 8'h00;
		end else begin
			net_ready_o <= 1'($urandom);
			if (net_valid_i && net_ready_o) begin
				got_o <= net_data_i;
				got_n_o <= got_n_o + 8'h01;
			end
		end
	end
endmodule

//--- tb_top.sv
// Self-checking bench for the reader control block.
`timescale 1ns/100ps
module tb_top;
	import reader_ctl_pkg::*;
	logic clk_i, rst_b_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, full;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, v;
	logic [3:0] s_axi_wstrb, address_low_selector_i, c;
	logic [1:0] s_axi_bresp, s_axi_rresp, display_screen_o;
	logic address_range_switch_i, read_trigger_i, result_done_i;
	logic result_good_i, result_valid_i, result_ready_o, read_gate_o;
	logic [7:0] result_data_i, i25_digits_o, net_data_o, got_o, got_n_o;
	logic [15:0] symbology_enable_o;
	logic master_ack_i, net_register_o, net_valid_o, net_ready_i;
	logic [4:0] net_address_o;
	logic host_txd_o, power_status_led_green_o, power_status_led_red_o;
	logic bus_status_led_green_o, bus_status_led_red_o, display_update_o;
	logic [7:0] q[$];
	int miscompares, samples_checked, tg, n, i;

	reader_startup_status_trigger #(.FLASH_CYC(8), .BLINK_LEN(5),
		.SCREEN_LEN(10), .BAUD_LEN(4)) uut (.*);
	net_master_model partner (.clk_i(clk_i),
		.rst_b_i(rst_b_i), .net_register_i(net_register_o),
		.net_valid_i(net_valid_o), .net_data_i(net_data_o),
		.master_ack_o(master_ack_i), .net_ready_o(net_ready_i),
		.got_o(got_o), .got_n_o(got_n_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic hang(input int k, input int lim);
		if (k >= lim) begin
			miscompares++;
			$display("MISMATCH t=%0t wait=%h limit=%h", $time, k, lim);
			end_sim;
		end
	endtask
	function automatic logic [1:0] led_exp(input logic [3:0] x);
		if (x[CTRL_FAULT_BIT])
			return 2'b01;
		if (x[CTRL_SERVICE_BIT])
			return 2'b11;
		return 2'b10;
	endfunction
	// Expected symbology word after a write with byte strobes; lane 3 is unused.
	function automatic logic [31:0] lane_mix(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		lane_mix = o & 32'h00FF_FFFF;
		for (int l = 0; l < 3; l++)
			if (s[l])
				lane_mix[8*l +: 8] = n[8*l +: 8];
	endfunction
	task automatic wrc(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && k < 99);
		s_axi_bready <= 1'b0;
		hang(k, 99);
		chk(s_axi_bresp, e);
		@(posedge clk_i);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && k < 99);
		s_axi_rready <= 1'b0;
		hang(k, 99);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
		@(posedge clk_i);
	endtask
	task automatic do_reset(input logic rng, input logic [3:0] low);
		rst_b_i <= 1'b0;
		address_range_switch_i <= rng;
		address_low_selector_i <= low;
		repeat (16) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
	endtask
	task automatic probe(input int s, input int len, output int t);
		logic p, x;
		t = 0;
		p = s == 0 ? power_status_led_green_o :
			s == 1 ? bus_status_led_green_o : bus_status_led_red_o;
		repeat (len) begin
			@(posedge clk_i);
			x = s == 0 ? power_status_led_green_o :
				s == 1 ? bus_status_led_green_o : bus_status_led_red_o;
			if (x !== p)
				t++;
			p = x;
		end
	endtask
	task automatic blink(input logic good, input logic [7:0] e);
		logic [7:0] s;
		logic [1:0] st, pr;
		int u;
		s = 8'h00;
		pr = 2'b10;
		u = 0;
		result_good_i <= good;
		result_done_i <= 1'b1;
		@(posedge clk_i);
		result_done_i <= 1'b0;
		repeat (30) begin
			@(posedge clk_i);
			st = {power_status_led_green_o, power_status_led_red_o};
			if (st !== pr)
				s = {s[5:0], st};
			pr = st;
			if (display_update_o === 1'b1)
				u++;
		end
		chk(s, e);
		chk(u, good);
	endtask
	// Valid stays up between bytes so it is never lowered and raised at once.
	task automatic push(input logic [7:0] d);
		int k;
		result_data_i <= d;
		result_valid_i <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
			if (result_ready_o !== 1'b1)
				full = 1'b1;
		end while (result_ready_o !== 1'b1 && k < 500);
		hang(k, 500);
	endtask
	task automatic rx(input logic net, output logic [7:0] d);
		logic [7:0] m;
		int k;
		m = got_n_o;
		for (k = 0; k < 2000 && (net ? got_n_o === m : host_txd_o !== 1'b0);
			k++)
			@(posedge clk_i);
		hang(k, 2000);
		d = got_o;
		if (!net) begin
			repeat (2) @(posedge clk_i);
			for (k = 0; k < 8; k++) begin
				repeat (4) @(posedge clk_i);
				d = {host_txd_o, d[7:1]};
			end
			repeat (4) @(posedge clk_i);
			chk(host_txd_o, 1);
		end
	endtask
	task automatic stream(input int cnt, input logic net);
		logic [7:0] d;
		q.delete();
		q.push_back(8'h00);
		q.push_back(8'hFF);
		while (q.size() < cnt)
			q.push_back(8'($urandom));
		fork
			begin
				foreach (q[k])
					push(q[k]);
				result_valid_i <= 1'b0;
			end
			foreach (q[j]) begin
				rx(net, d);
				chk(d, q[j]);
			end
		join
	endtask

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, read_trigger_i, result_done_i, result_good_i} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, result_data_i} = '0;
		{result_valid_i, full, rst_b_i} = 3'h0;
		s_axi_wstrb = 4'hF;
		miscompares = 0;
		samples_checked = 0;
		void'($urandom(32'h7C1A));
		do_reset(1'b0, 4'h0);
		probe(0, 20, tg);
		chk(tg > 1, 1);
		for (n = 0; n < 99 && display_screen_o !== 2'h2; n++)
			@(posedge clk_i);
		hang(n, 99);
		rchk(OFS_STATUS, 32'h31, RESP_OKAY);
		rchk(OFS_SYMB, 32'h000A_FFFF, RESP_OKAY);
		chk({symbology_enable_o, i25_digits_o}, 24'hFFFF0A);
		rchk(OFS_ADDR, 0, RESP_OKAY);
		rchk(8'h10, 0, RESP_SLVERR);
		wrc(OFS_STATUS, 32'hFFFF_FFFF, RESP_SLVERR);
		v = $urandom & 32'h00FF_FFFF;
		wrc(OFS_SYMB, v, RESP_OKAY);
		rchk(OFS_SYMB, v, RESP_OKAY);
		chk({symbology_enable_o, i25_digits_o}, {v[15:0], v[23:16]});
		c = 4'($urandom);
		s_axi_wstrb <= c;
		wrc(OFS_SYMB, ~v, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rchk(OFS_SYMB, lane_mix(v, ~v, c), RESP_OKAY);
		read_trigger_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(read_gate_o, 1);
		read_trigger_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(read_gate_o, 0);
		blink(1'b1, 8'h02);
		blink(1'b0, 8'h06);
		for (i = 0; i < 7; i++) begin
			c = i < 4 ? 4'(i) : 4'($urandom);
			c = i == 6 ? 4'h0 : c;
			wrc(OFS_CTRL, {28'h0, c}, RESP_OKAY);
			rchk(OFS_CTRL, {28'h0, c}, RESP_OKAY);
			chk({power_status_led_green_o, power_status_led_red_o},
				led_exp(c));
		end
		stream(34, 1'b0);
		chk(full, 1);
		rchk(OFS_STATUS, 32'h31, RESP_OKAY);
		i = $urandom % 16;
		do_reset(1'b1, 4'(i));
		probe(1, 20, tg);
		chk(tg > 1, 1);
		for (n = 0; n < 99 && master_ack_i !== 1'b1; n++)
			@(posedge clk_i);
		hang(n, 99);
		address_low_selector_i <= ~4'(i);
		repeat (3) @(posedge clk_i);
		chk({bus_status_led_green_o, bus_status_led_red_o}, 2'b10);
		rchk(OFS_ADDR, 16 + i, RESP_OKAY);
		rchk(OFS_STATUS, 32'h37, RESP_OKAY);
		stream(8, 1'b1);
		wrc(OFS_CTRL, 32'h4, RESP_OKAY);
		probe(2, 40, tg);
		chk(tg > 1, 1);
		wrc(OFS_CTRL, 32'h8, RESP_OKAY);
		probe(2, 20, tg);
		chk({tg == 0, bus_status_led_red_o}, 2'b11);
		end_sim;
	end
endmodule
